/* rtl/usbrm_pkg.sv */
package usbrm_pkg;

  // ----------------------------------------------------------------
  // Word offsets of the module map (word index, byte address = 4x)
  // ----------------------------------------------------------------
  localparam logic [12:0] OFS_DMA_OUT = 13'h0008;
  localparam logic [12:0] OFS_DMA_GAP = 13'h0040;
  localparam logic [12:0] OFS_DMA_IN = 13'h0048;
  localparam logic [12:0] OFS_BUF = 13'h0080;
  localparam logic [12:0] OFS_OUT0_BUF = 13'h0E80;
  localparam logic [12:0] OFS_IN0_BUF = 13'h0EC0;
  localparam logic [12:0] OFS_SETUP = 13'h0F00;
  localparam logic [12:0] OFS_DEF_OUT = 13'h0F08;
  localparam logic [12:0] OFS_DEF_GAP = 13'h0F40;
  localparam logic [12:0] OFS_DEF_IN = 13'h0F48;
  localparam logic [12:0] OFS_GEN = 13'h0F80;
  localparam logic [12:0] OFS_GCTL = 13'h0F91;
  localparam logic [12:0] OFS_RSV_A_LO = 13'h0F84;
  localparam logic [12:0] OFS_RSV_A_HI = 13'h0F90;
  localparam logic [12:0] OFS_RSV_B_LO = 13'h0F9D;
  localparam logic [12:0] OFS_RSV_B_HI = 13'h0FF7;
  localparam logic [12:0] OFS_RSV_C = 13'h0FFB;
  localparam logic [12:0] OFS_USB_CONTROL = 13'h0FFC;
  localparam logic [12:0] OFS_IDLE_CTL = 13'h1000;
  localparam logic [12:0] OFS_INT_ST = 13'h1001;
  localparam logic [12:0] OFS_INT_MASK = 13'h1002;

  // ----------------------------------------------------------------
  // Sizes of the map regions
  // ----------------------------------------------------------------
  localparam int EP_COUNT = 7;
  localparam int BLK_WORDS = 8;
  localparam int BLK_TOTAL = 2 * EP_COUNT;
  localparam int REG_WORDS = BLK_TOTAL * BLK_WORDS;
  localparam int BUF_BYTES = 3584;
  localparam int EP0_BUF_LEN = 64;
  localparam int SETUP_LEN = 8;
  localparam int RAM_DEPTH = BUF_BYTES + 2 * EP0_BUF_LEN + SETUP_LEN;
  localparam int GEN_BYTES = 128;
  localparam logic [6:0] IN_BLK_BASE = 7'h38;
  localparam logic [6:0] GEN_IDX_GCTL = 7'h11;
  localparam logic [6:0] GEN_IDX_USB_CONTROL = 7'h7C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int GCTL_SOFT_RESET_POS = 0;
  localparam int USB_CONTROL_CONNECT_POS = 7;
  localparam int IDLE_RSTN_POS = 0;
  localparam int DMA_GO_POS = 0;
  localparam logic [7:0] USB_CONTROL_RST = 8'h00;
  localparam int INT_W = 3;
  localparam int INT_SOFT_POS = 0;
  localparam int INT_REFUSED_POS = 1;
  localparam int INT_MEMDONE_POS = 2;

  // Address regions seen by the decoder
  typedef enum logic [3:0] {
    R_NONE, R_RSV, R_DMA, R_BUF, R_DEF, R_GEN, R_IDLE, R_IST, R_IMSK
  } usbrm_region_t;

endpackage : usbrm_pkg

/* rtl/usbrm_buf_ram.sv */
`timescale 1ns/1ps
module usbrm_buf_ram
  import usbrm_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic we,
  input wire logic re,
  input wire logic [11:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata_q
);

  // ----------------------------------------------------------------
  // Packet, control endpoint and setup byte storage
  // ----------------------------------------------------------------
  logic [7:0] mem [RAM_DEPTH];
  logic [7:0] rdata_d;

  // Read data is held until the next read
  always_comb begin
    rdata_d = rdata_q;
    if (re) begin
      rdata_d = mem[addr];
    end
  end

  // Storage has no reset, only the read register does
  always_ff @(posedge pclk) begin
    if (pclk_en && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 8'h00;
    end else if (pclk_en) begin
      rdata_q <= rdata_d;
    end
  end

endmodule : usbrm_buf_ram

/* rtl/usbrm_top.sv */
// How it works
// - Soft reset bit gives one-cycle reset
// - Soft reset drops the bus connection
// - Soft reset keeps the USB control register
// - Module reset bit low holds reset
// - Held reset restores defaults, disconnects bus
// - Map accesses refused while held in reset
// - Chip reset clears the module reset bit
// - Debugger halt never freezes the module
// - Enabled interrupt level can wake CPU
// - Memory transfers wait while system DMA idle
// - Decode is parameterised base plus offset
// - Reserved head, then OUT DMA blocks
// - Reserved gap, then IN DMA blocks
// - Shared packet buffer region of 3584 bytes
// - Control endpoint receive and transmit buffers
// - Eight byte setup packet buffer
// - OUT and IN definition blocks, gap
//
// The APB interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module usbrm_top
  import usbrm_pkg::*;
#(
  parameter logic [31:0] BASE_ADDR = 32'h0000_0000
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pclk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sysdma_avail,
  input wire logic mem_ack,
  output logic mem_req,
  output logic [3:0] mem_blk,
  output logic bus_connect,
  output logic irq
);
  import usbrm_pkg::*;

  // ----------------------------------------------------------------
  // State of the block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [REG_WORDS-1:0][15:0] dma;
    logic [REG_WORDS-1:0][7:0] defr;
    logic [GEN_BYTES-1:0][7:0] gen;
    logic mod_rst_n;
    logic attach_arm;
    logic soft_pend;
    logic wait1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [INT_W-1:0] int_st;
    logic [INT_W-1:0] int_mask;
    logic irq;
    logic mem_req;
    logic [3:0] mem_blk;
    logic bus_connect;
  } usbrm_state_t;

  usbrm_state_t s_q;
  usbrm_state_t s_d;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  logic [12:0] off;
  logic base_hit;
  usbrm_region_t region;
  logic [6:0] blk_idx;
  logic [12:0] diff;
  logic access;
  logic mapped;
  logic blocked;

  assign off = paddr[14:2];
  assign base_hit = (paddr[31:15] == BASE_ADDR[31:15]);
  assign access = psel && penable;

  // Map word offset to region and entry index
  always_comb begin
    region = R_NONE;
    diff = 13'h0000;
    if (!base_hit) begin
      region = R_NONE;
    end else if (off < OFS_DMA_OUT) begin
      region = R_RSV;
    end else if (off < OFS_DMA_GAP) begin
      region = R_DMA;
      diff = off - OFS_DMA_OUT;
    end else if (off < OFS_DMA_IN) begin
      region = R_RSV;
    end else if (off < OFS_BUF) begin
      region = R_DMA;
      diff = off - OFS_DMA_IN + {6'h00, IN_BLK_BASE};
    end else if (off < OFS_DEF_OUT) begin
      region = R_BUF;
      diff = off - OFS_BUF;
    end else if (off < OFS_DEF_GAP) begin
      region = R_DEF;
      diff = off - OFS_DEF_OUT;
    end else if (off < OFS_DEF_IN) begin
      region = R_RSV;
    end else if (off < OFS_GEN) begin
      region = R_DEF;
      diff = off - OFS_DEF_IN + {6'h00, IN_BLK_BASE};
    end else if (off < OFS_IDLE_CTL) begin
      diff = off - OFS_GEN;
      if ((off >= OFS_RSV_A_LO && off <= OFS_RSV_A_HI) ||
          (off >= OFS_RSV_B_LO && off <= OFS_RSV_B_HI) || off == OFS_RSV_C) begin
        region = R_RSV;
      end else begin
        region = R_GEN;
      end
    end else if (off == OFS_IDLE_CTL) begin
      region = R_IDLE;
    end else if (off == OFS_INT_ST) begin
      region = R_IST;
    end else if (off == OFS_INT_MASK) begin
      region = R_IMSK;
    end else begin
      region = R_NONE;
    end
  end

  assign blk_idx = diff[6:0];
  assign mapped = (region == R_RSV) || (region == R_DMA) || (region == R_BUF) ||
                  (region == R_DEF) || (region == R_GEN);
  assign blocked = mapped && !s_q.mod_rst_n;

  // ----------------------------------------------------------------
  // Buffer memory
  // ----------------------------------------------------------------
  logic ram_we;
  logic ram_re;
  logic [7:0] ram_rdata;

  usbrm_buf_ram u_buf (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .we(ram_we),
    .re(ram_re),
    .addr(diff[11:0]),
    .wdata(pwdata[7:0]),
    .rdata_q(ram_rdata)
  );

  // ----------------------------------------------------------------
  // Transfer start flags of the fourteen DMA blocks
  // ----------------------------------------------------------------
  logic [BLK_TOTAL-1:0] go_q;
  genvar gb;
  generate
    for (gb = 0; gb < BLK_TOTAL; gb++) begin : g_go
      assign go_q[gb] = s_q.dma[gb * BLK_WORDS][DMA_GO_POS];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [BLK_TOTAL-1:0] done_mask;
  logic [INT_W-1:0] ev;
  logic mem_done;

  always_comb begin
    s_d = s_q;
    ram_we = 1'b0;
    ram_re = 1'b0;
    ev = '0;
    done_mask = '0;
    mem_done = s_q.mem_req && mem_ack && sysdma_avail;

    // Momentary reset of the DMA, definition and general registers except the USB control register
    if (s_q.soft_pend) begin
      s_d.dma = '0;
      s_d.defr = '0;
      for (int i = 0; i < GEN_BYTES; i++) begin
        if (i[6:0] != GEN_IDX_USB_CONTROL) begin
          s_d.gen[i] = 8'h00;
        end
      end
      s_d.attach_arm = 1'b0;
      s_d.soft_pend = 1'b0;
      ev[INT_SOFT_POS] = 1'b1;
      mem_done = 1'b0;
    end

    // Held module reset forces power-on defaults
    if (!s_q.mod_rst_n) begin
      s_d.dma = '0;
      s_d.defr = '0;
      s_d.gen = '0;
      s_d.gen[GEN_IDX_USB_CONTROL] = USB_CONTROL_RST;
      s_d.attach_arm = 1'b0;
      s_d.soft_pend = 1'b0;
      mem_done = 1'b0;
    end

    // APB: two wait cycles, write commits on the completing edge
    if (access && !s_q.pready) begin
      if (!s_q.wait1) begin
        s_d.wait1 = 1'b1;
        ram_re = (region == R_BUF) && !blocked;
      end else begin
        s_d.wait1 = 1'b0;
        s_d.pready = 1'b1;
        s_d.pslverr = (region == R_NONE) || blocked;
        s_d.prdata = 32'h0000_0000;
        ev[INT_REFUSED_POS] = blocked;
        if (!blocked) begin
          if (region == R_DMA) begin
            s_d.prdata[15:0] = s_q.dma[blk_idx];
          end else if (region == R_BUF) begin
            s_d.prdata[7:0] = ram_rdata;
          end else if (region == R_DEF) begin
            s_d.prdata[7:0] = s_q.defr[blk_idx];
          end else if (region == R_GEN) begin
            s_d.prdata[7:0] = s_q.gen[blk_idx];
          end else if (region == R_IDLE) begin
            s_d.prdata[IDLE_RSTN_POS] = s_q.mod_rst_n;
          end else if (region == R_IST) begin
            s_d.prdata[INT_W-1:0] = s_q.int_st;
          end else if (region == R_IMSK) begin
            s_d.prdata[INT_W-1:0] = s_q.int_mask;
          end
        end
      end
    end else if (access && s_q.pready) begin
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
      if (pwrite && !s_q.pslverr) begin
        if (region == R_DMA) begin
          s_d.dma[blk_idx] = pwdata[15:0];
        end else if (region == R_BUF) begin
          ram_we = 1'b1;
        end else if (region == R_DEF) begin
          s_d.defr[blk_idx] = pwdata[7:0];
        end else if (region == R_GEN && blk_idx == GEN_IDX_GCTL) begin
          s_d.gen[blk_idx] = pwdata[7:0];
          s_d.gen[blk_idx][GCTL_SOFT_RESET_POS] = 1'b0;
          s_d.soft_pend = pwdata[GCTL_SOFT_RESET_POS];
        end else if (region == R_GEN) begin
          s_d.gen[blk_idx] = pwdata[7:0];
          if (blk_idx == GEN_IDX_USB_CONTROL && pwdata[USB_CONTROL_CONNECT_POS]) begin
            s_d.attach_arm = 1'b1;
          end
        end else if (region == R_IDLE) begin
          s_d.mod_rst_n = pwdata[IDLE_RSTN_POS];
        end else if (region == R_IST) begin
          s_d.int_st = s_q.int_st & ~pwdata[INT_W-1:0];
        end else if (region == R_IMSK) begin
          s_d.int_mask = pwdata[INT_W-1:0];
        end
      end
    end else begin
      s_d.wait1 = 1'b0;
      s_d.pready = 1'b0;
      s_d.pslverr = 1'b0;
    end

    // Completed memory transfer clears the lowest pending block
    if (mem_done) begin
      for (int b = BLK_TOTAL - 1; b >= 0; b--) begin
        if (go_q[b]) begin
          done_mask = '0;
          done_mask[b] = 1'b1;
        end
      end
      for (int b = 0; b < BLK_TOTAL; b++) begin
        if (done_mask[b]) begin
          s_d.dma[b * BLK_WORDS][DMA_GO_POS] = 1'b0;
        end
      end
      ev[INT_MEMDONE_POS] = 1'b1;
    end

    // Request stays up until acknowledged with a memory path present
    s_d.mem_req = |(go_q & ~done_mask) && s_q.mod_rst_n && !s_q.soft_pend;
    s_d.mem_blk = 4'h0;
    for (int b = BLK_TOTAL - 1; b >= 0; b--) begin
      if (go_q[b] && !done_mask[b]) begin
        s_d.mem_blk = b[3:0];
      end
    end

    // Events win over a same-cycle clear
    s_d.int_st = s_d.int_st | ev;
    s_d.irq = |(s_d.int_st & s_d.int_mask);
    s_d.bus_connect = s_d.gen[GEN_IDX_USB_CONTROL][USB_CONTROL_CONNECT_POS] &&
                      s_d.attach_arm && s_d.mod_rst_n;
  end

  // ----------------------------------------------------------------
  // State register; only the clock enable stalls it
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else if (pclk_en) begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign mem_req = s_q.mem_req;
  assign mem_blk = s_q.mem_blk;
  assign bus_connect = s_q.bus_connect;
  assign irq = s_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_soft_once;
    @(posedge pclk) disable iff (!presetn) s_q.soft_pend && pclk_en |=> !s_q.soft_pend;
  endproperty
  a_soft_once: assert property (p_soft_once) else $error("soft reset not momentary");

  property p_soft_disc;
    @(posedge pclk) disable iff (!presetn) s_q.soft_pend && pclk_en |=> !bus_connect;
  endproperty
  a_soft_disc: assert property (p_soft_disc) else $error("connected after soft reset");

  property p_soft_ctl;
    @(posedge pclk) disable iff (!presetn)
      s_q.soft_pend && pclk_en |=>
        s_q.gen[GEN_IDX_USB_CONTROL] == $past(s_q.gen[GEN_IDX_USB_CONTROL]);
  endproperty
  a_soft_ctl: assert property (p_soft_ctl) else $error("control reg changed by soft reset");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
      !s_q.mod_rst_n && !(access && region == R_IDLE) |=> !s_q.mod_rst_n;
  endproperty
  a_hold: assert property (p_hold) else $error("module reset released by itself");

  property p_held_dflt;
    @(posedge pclk) disable iff (!presetn)
      !s_q.mod_rst_n && pclk_en |=>
        !bus_connect && s_q.gen[GEN_IDX_USB_CONTROL] == USB_CONTROL_RST;
  endproperty
  a_held_dflt: assert property (p_held_dflt) else $error("defaults not forced");

  property p_refuse;
    @(posedge pclk) disable iff (!presetn)
      access && !s_q.pready && s_q.wait1 && blocked && pclk_en |=> pready && pslverr;
  endproperty
  a_refuse: assert property (p_refuse) else $error("access reached held module");

  property p_chip;
    @(posedge pclk) $rose(presetn) |-> !s_q.mod_rst_n;
  endproperty
  a_chip: assert property (p_chip) else $error("module reset bit not cleared");

  property p_wake;
    @(posedge pclk) disable iff (!presetn) irq == |(s_q.int_st & s_q.int_mask);
  endproperty
  a_wake: assert property (p_wake) else $error("enabled interrupt not raised");

  property p_wait;
    @(posedge pclk) disable iff (!presetn)
      |go_q && !sysdma_avail && !access && s_q.mod_rst_n && !s_q.soft_pend && pclk_en
      |=> mem_req;
  endproperty
  a_wait: assert property (p_wait) else $error("transfer finished without memory path");

  property p_rsv_zero;
    @(posedge pclk) disable iff (!presetn)
      access && s_q.wait1 && !s_q.pready && region == R_RSV && pclk_en |=> prdata == 32'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read not zero");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn) access && pready && !base_hit |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("foreign address accepted");

  c_soft: cover property (@(posedge pclk) disable iff (!presetn) s_q.soft_pend);
  c_refused: cover property (@(posedge pclk) disable iff (!presetn) pready && pslverr);
  c_memdone: cover property (@(posedge pclk) disable iff (!presetn) mem_req && mem_ack
                             && sysdma_avail);

endmodule : usbrm_top

/* tb/usbrm_dma_model.sv */
`timescale 1ns/1ps
module usbrm_dma_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic stall,
  input wire logic [1:0] lat,
  output logic sysdma_avail,
  output logic mem_ack
);
  logic [1:0] cnt_q;
  // No path to memory while the system DMA is idled or halted on a break
  assign sysdma_avail = !stall;
  // One-cycle acknowledge after a delay of lat cycles, only with a path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 2'h0;
      mem_ack <= 1'b0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      cnt_q <= 2'h0;
    end else if (mem_req && sysdma_avail) begin
      if (cnt_q >= lat) begin
        mem_ack <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 2'h1;
      end
    end else begin
      cnt_q <= 2'h0;
    end
  end
endmodule : usbrm_dma_model

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import usbrm_pkg::*;
  localparam logic [31:0] BA = 32'h0001_8000;
  typedef struct {logic rd; logic er; logic [31:0] d;} usbrm_note_t;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, stall;
  logic pclk_en = 1'b1;
  logic [31:0] paddr, pwdata, prdata, m;
  logic [31:0] rv [10];
  logic pready, pslverr, sysdma_avail, mem_ack, mem_req, bus_connect, irq;
  logic [3:0] mem_blk;
  logic [1:0] lat;
  logic [12:0] ofs_rw [10] = '{13'h0009, 13'h007F, 13'h0080, 13'h0E7F, 13'h0E80,
                               13'h0EC0, 13'h0F00, 13'h0F07, 13'h0F08, 13'h0F48};
  logic [12:0] ofs_rsv [6] = '{13'h0000, 13'h0007, 13'h0040, 13'h0047, 13'h0F40, 13'h0F47};
  int n_fail = 0;
  int n_compared = 0;
  int seed = 81661;
  int cyc = 0;
  int k;
  usbrm_note_t q[$];
  usbrm_note_t nt;

  // Clock
  always #4 pclk = ~pclk;

  usbrm_top #(.BASE_ADDR(BA)) i_usbrm_top (.pclk(pclk), .presetn(presetn),
    .pclk_en(pclk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sysdma_avail(sysdma_avail), .mem_ack(mem_ack), .mem_req(mem_req),
    .mem_blk(mem_blk), .bus_connect(bus_connect), .irq(irq));
  usbrm_dma_model i_usbrm_dma_model (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
    .stall(stall), .lat(lat), .sysdma_avail(sysdma_avail), .mem_ack(mem_ack));

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task finish_test;
    if (n_fail == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // APB master
  // ----------------------------------------------------------------
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e,
           input logic er);
    q.push_back('{!w, er, e});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus

  task wr(input logic [12:0] o, input logic [31:0] d, input logic er);
    bus(1'b1, BA + 32'(o) * 4, d, 32'h0, er);
  endtask : wr

  task rd(input logic [12:0] o, input logic [31:0] e, input logic er);
    bus(1'b0, BA + 32'(o) * 4, 32'h0, e, er);
  endtask : rd

  // Result monitor takes the oldest note at each completed transfer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      nt = q.pop_front();
      chk("pslverr", 32'(nt.er), 32'(pslverr));
      if (nt.rd) chk("prdata", nt.d, prdata);
    end
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    stall = 1'b1;
    lat = 2'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Held after chip reset, map refused
    rd(OFS_IDLE_CTL, 32'h0, 1'b0);
    wr(13'h0009, 32'h0005, 1'b1);
    rd(13'h0009, 32'h0, 1'b1);
    rd(OFS_INT_ST, 32'h2, 1'b0);
    wr(OFS_IDLE_CTL, 32'h1, 1'b0);
    rd(OFS_IDLE_CTL, 32'h1, 1'b0);
    // Map regions at their boundaries, random data
    for (int i = 0; i < 10; i++) begin
      m = (ofs_rw[i] < OFS_BUF) ? 32'hFFFF : 32'hFF;
      rv[i] = $random(seed) & m;
      wr(ofs_rw[i], rv[i], 1'b0);
    end
    // All written before any read, so two regions sharing storage show up
    for (int i = 0; i < 10; i++) begin
      rd(ofs_rw[i], rv[i], 1'b0);
    end
    for (int i = 0; i < 6; i++) begin
      wr(ofs_rsv[i], $random(seed), 1'b0);
      rd(ofs_rsv[i], 32'h0, 1'b0);
    end
    bus(1'b0, BA ^ 32'h0000_8000, 32'h0, 32'h0, 1'b1);
    rd(13'h1003, 32'h0, 1'b1);
    // Soft reset, interrupt raise, mask and clear
    wr(OFS_INT_ST, 32'h7, 1'b0);
    wr(OFS_USB_CONTROL, 32'h80, 1'b0);
    repeat (4) @(posedge pclk);
    chk("bus_connect", 32'h1, 32'(bus_connect));
    wr(13'h0009, 32'h1234, 1'b0);
    wr(OFS_INT_MASK, 32'h1, 1'b0);
    chk("irq", 32'h0, 32'(irq));
    wr(OFS_GCTL, 32'h1, 1'b0);
    // Clock enable low holds the pending soft reset back
    pclk_en <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("bus_connect", 32'h1, 32'(bus_connect));
    pclk_en <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("bus_connect", 32'h0, 32'(bus_connect));
    chk("irq", 32'h1, 32'(irq));
    rd(OFS_USB_CONTROL, 32'h80, 1'b0);
    rd(13'h0009, 32'h0, 1'b0);
    rd(OFS_GCTL, 32'h0, 1'b0);
    rd(OFS_INT_ST, 32'h1, 1'b0);
    wr(OFS_INT_MASK, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, 32'(irq));
    wr(OFS_INT_MASK, 32'h1, 1'b0);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, 32'(irq));
    wr(OFS_INT_ST, 32'h1, 1'b0);
    repeat (2) @(posedge pclk);
    chk("irq", 32'h0, 32'(irq));
    wr(13'h0009, 32'h55AA, 1'b0);
    rd(13'h0009, 32'h55AA, 1'b0);
    // Memory transfers wait while the system DMA is idle
    wr(OFS_DMA_OUT, 32'h1, 1'b0);
    wr(13'h0050, 32'h1, 1'b0);
    repeat (5) @(posedge pclk);
    chk("mem_req", 32'h1, 32'(mem_req));
    chk("mem_blk", 32'h0, 32'(mem_blk));
    rd(OFS_DMA_OUT, 32'h1, 1'b0);
    stall <= 1'b0;
    lat <= 2'h3;
    k = 0;
    while (mem_ack !== 1'b1 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    @(negedge pclk);
    chk("mem_blk", 32'h8, 32'(mem_blk));
    k = 0;
    while (mem_req !== 1'b0 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    chk("mem_req", 32'h0, 32'(mem_req));
    rd(OFS_INT_ST, 32'h4, 1'b0);
    rd(13'h0050, 32'h0, 1'b0);
    // Held module reset restores defaults
    wr(OFS_USB_CONTROL, 32'h80, 1'b0);
    repeat (4) @(posedge pclk);
    chk("bus_connect", 32'h1, 32'(bus_connect));
    wr(OFS_IDLE_CTL, 32'h0, 1'b0);
    repeat (2) @(posedge pclk);
    chk("bus_connect", 32'h0, 32'(bus_connect));
    rd(OFS_USB_CONTROL, 32'h0, 1'b1);
    wr(OFS_IDLE_CTL, 32'h1, 1'b0);
    rd(OFS_USB_CONTROL, 32'h0, 1'b0);
    rd(13'h0009, 32'h0, 1'b0);
    // Chip reset in mid-run
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("irq", 32'h0, 32'(irq));
    presetn <= 1'b1;
    rd(OFS_IDLE_CTL, 32'h0, 1'b0);
    wr(13'h0009, 32'h0001, 1'b1);
    repeat (2) @(posedge pclk);
    finish_test();
  end
endmodule : testbench
